// File: rtl/psau_top.v
// Contract
// - Table address is table page above effective address.
// - Table page bit 7 selects configuration memory.
// - Window only with address bit 15 and enable.
// - Window page sits above address bits 14 to 0.
// - Windowed bit 15 is window page bit 0.
// - Program counter steps by two per word.
// - Low word read gives bits 15 to 0.
// - Low byte read: select one gives upper byte.
// - High word read gives bits 23 to 16, top zero.
// - Phantom byte reads as zero.
// - Low accesses reach bits 15 to 0, high 23 to 16.
// - Windowed reads stretch the instruction.
// - Outside repeat, move one extra cycle, others two.
// - Inside repeat, edge iterations two extra, others none.
// - No windowing during table accesses.
// - Rows of 64 words, pages of eight rows, aligned.
// - Erase a page; program a row or a word.
// - Table writes only fill the buffer, two cycles.
// - Each row needs its own programming cycle.
// - Start bit launches; hardware clears it when done.
// - Processor stalls while a flash operation runs.
// - Erase code 0010 erases a page; 0001 programs a row.
`timescale 1ns/1ps
`default_nettype none
`include "psau_defs.vh"

module psau_top
(
    input  wire        clk_i,            // Clock
    input  wire        rst_i,            // Reset
    // Wishbone slave
    input  wire [7:0]  wb_adr_i,         // Address
    input  wire [31:0] wb_dat_i,         // Write data
    output reg  [31:0] wb_dat_o,         // Read data
    input  wire        wb_we_i,          // Write enable
    input  wire [3:0]  wb_sel_i,         // Byte enables
    input  wire        wb_stb_i,         // Strobe
    input  wire        wb_cyc_i,         // Cycle
    output reg         wb_ack_o,         // Acknowledge
    // Core access port
    input  wire        acc_req_i,        // Request
    input  wire [2:0]  acc_kind_i,       // Kind
    input  wire        acc_byte_i,       // Byte mode
    input  wire        acc_move_i,       // Move
    input  wire [15:0] ea_i,             // Effective address
    input  wire [15:0] acc_wdata_i,      // Write data
    input  wire        rep_active_i,     // In repeat
    input  wire        rep_first_i,      // First iteration
    input  wire        rep_last_i,       // Last iteration
    input  wire        rep_int_exit_i,   // Interrupt exit
    input  wire        rep_reentry_i,    // Re-entry
    output reg         acc_ack_o,        // Answer
    output reg  [15:0] acc_rdata_o,      // Read data
    output reg  [1:0]  acc_extra_o,      // Extra cycles
    output reg         acc_window_o,     // Window used
    output reg         acc_config_o,     // Configuration
    output reg  [23:0] prog_addr_o,      // Program address
    output wire        stall_o,          // Stall
    // Program counter
    input  wire        pc_load_i,        // Load
    input  wire [22:0] pc_load_val_i,    // Load value
    input  wire        pc_step_i,        // Step
    output reg  [23:0] fetch_addr_o,     // Fetch address
    // Flash array
    output wire [23:0] flash_rd_addr_o,  // Read address
    input  wire [23:0] flash_rd_data_i,  // Read word
    output reg         op_start_o,       // Launch pulse
    output reg  [2:0]  op_kind_o,        // {word, row, page}
    output reg  [23:0] op_addr_o,        // Target
    input  wire        op_done_i,        // Done pulse
    input  wire [5:0]  buf_idx_i,        // Buffer index
    output reg  [23:0] buf_word_o        // Buffer word
);

    reg  [7:0]  table_page_reg;
    reg  [7:0]  window_page_reg;
    reg  [15:0] core_control_reg;
    reg         flash_wren;
    reg         flash_erase;
    reg  [3:0]  flash_op_select;
    reg  [23:0] hold_buf [0:`PSAU_ROW_WORDS-1];
    reg  [23:0] last_write_addr;
    reg  [22:0] pc;
    reg         wr_pending;
    reg  [23:0] next_addr;
    reg  [1:0]  next_extra;

    wire        bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        bus_wr    = bus_req && wb_we_i;
    wire        hit_tp    = (wb_adr_i == `PSAU_OFS_TABLE_PAGE);
    wire        hit_wp    = (wb_adr_i == `PSAU_OFS_WINDOW_PAGE);
    wire        hit_cc    = (wb_adr_i == `PSAU_OFS_CORE_CONTROL);
    wire        hit_fc    = (wb_adr_i == `PSAU_OFS_FLASH_CONTROL);
    wire        hit_key   = (wb_adr_i == `PSAU_OFS_FLASH_KEY);
    wire        wr_lo     = bus_wr && wb_sel_i[0];
    wire        wr_hi     = bus_wr && wb_sel_i[1];
    wire        busy;
    wire        wrerr;
    wire        seq_start;
    wire [2:0]  seq_kind;
    wire [15:0] fmt_data;

    wire        kind_table = (acc_kind_i != `PSAU_K_DATA_READ);
    wire        kind_high  = (acc_kind_i == `PSAU_K_READ_HIGH) || (acc_kind_i == `PSAU_K_WRITE_HIGH);
    wire        kind_write = (acc_kind_i == `PSAU_K_WRITE_LOW) || (acc_kind_i == `PSAU_K_WRITE_HIGH);
    wire        byte_sel   = ea_i[0];
    wire        win_en     = core_control_reg[`PSAU_CC_WINDOW_ENABLE];
    // Table accesses never take the window, even with the enable set.
    wire        win_hit    = !kind_table && ea_i[15] && win_en;
    wire        take       = acc_req_i && !busy;
    wire [5:0]  buf_slot   = ea_i[6:1];
    wire        rep_edge   = rep_first_i || rep_last_i || rep_int_exit_i || rep_reentry_i;

    assign stall_o = busy;
    assign flash_rd_addr_o = next_addr;

    // Program address formation.
    always @*
    begin
        if (kind_table)
            next_addr = {table_page_reg, ea_i};
        else if (win_hit)
            next_addr = {1'b0, window_page_reg, ea_i[14:0]};
        else
            next_addr = {8'h00, ea_i};
    end

    // Extra cycles for table writes and windowed reads.
    always @*
    begin
        if (kind_write)
            next_extra = `PSAU_EXTRA_TABLE_WRITE;
        else if (!win_hit)
            next_extra = `PSAU_EXTRA_NONE;
        else if (rep_active_i)
            next_extra = rep_edge ? `PSAU_EXTRA_OTHER : `PSAU_EXTRA_NONE;
        else
            next_extra = acc_move_i ? `PSAU_EXTRA_MOVE : `PSAU_EXTRA_OTHER;
    end

    psau_read_format u_format
    (
        .high_i  (kind_high),
        .byte_i  (acc_byte_i),
        .sel_i   (byte_sel),
        .pword_i (flash_rd_data_i),
        .data_o  (fmt_data)
    );

    psau_flash_seq u_seq
    (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .key_we_i   (wr_lo && hit_key),
        .key_data_i (wb_dat_i[7:0]),
        .bus_we_i   (bus_wr),
        .wr_req_i   (wr_hi && hit_fc && wb_dat_i[`PSAU_FC_WR]),
        .err_clr_i  (wr_hi && hit_fc && !wb_dat_i[`PSAU_FC_WRERR]),
        .wren_i     (wr_pending),
        .erase_i    (flash_erase),
        .op_i       (flash_op_select),
        .done_i     (op_done_i),
        .busy_o     (busy),
        .wrerr_o    (wrerr),
        .start_o    (seq_start),
        .kind_o     (seq_kind)
    );

    // Every bus access is answered one cycle after it is taken.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o         <= 1'b0;
            wb_dat_o         <= 32'h0000_0000;
            table_page_reg   <= `PSAU_RST_PAGE;
            window_page_reg  <= `PSAU_RST_PAGE;
            core_control_reg <= `PSAU_RST_CTRL;
            flash_wren       <= 1'b0;
            flash_erase      <= 1'b0;
            flash_op_select  <= 4'h0;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h0000_0000;
            if (bus_req && !wb_we_i)
            begin
                if (hit_tp)
                    wb_dat_o <= {24'h00_0000, table_page_reg};
                else if (hit_wp)
                    wb_dat_o <= {24'h00_0000, window_page_reg};
                else if (hit_cc)
                    wb_dat_o <= {16'h0000, core_control_reg};
                else if (hit_fc)
                    wb_dat_o <= {16'h0000, busy, flash_wren, wrerr, 6'h00, flash_erase, 2'h0, flash_op_select};
            end
            if (wr_lo && hit_tp)
                table_page_reg <= wb_dat_i[7:0];
            if (wr_lo && hit_wp)
                window_page_reg <= wb_dat_i[7:0];
            if (wr_lo && hit_cc)
                core_control_reg[7:0] <= wb_dat_i[7:0];
            if (wr_hi && hit_cc)
                core_control_reg[15:8] <= wb_dat_i[15:8];
            // Mode bits are frozen while an operation runs so the launch stays coherent.
            if (wr_lo && hit_fc && !busy)
            begin
                flash_erase     <= wb_dat_i[`PSAU_FC_ERASE];
                flash_op_select <= wb_dat_i[3:0];
            end
            if (wr_hi && hit_fc && !busy)
                flash_wren <= wb_dat_i[`PSAU_FC_WREN];
        end
    end

    // One write may set the enable and the start bit together.
    always @*
    begin
        wr_pending = flash_wren;
        if (wr_hi && hit_fc && !busy)
            wr_pending = wb_dat_i[`PSAU_FC_WREN];
    end

    // Table writes touch only the holding buffer.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            acc_ack_o       <= 1'b0;
            acc_rdata_o     <= 16'h0000;
            acc_extra_o     <= `PSAU_EXTRA_NONE;
            acc_window_o    <= 1'b0;
            acc_config_o    <= 1'b0;
            prog_addr_o     <= 24'h00_0000;
            last_write_addr <= 24'h00_0000;
        end
        else
        begin
            acc_ack_o <= take;
            if (take)
            begin
                acc_extra_o  <= next_extra;
                acc_window_o <= win_hit;
                acc_config_o <= kind_table && table_page_reg[`PSAU_TP_CONFIG];
                prog_addr_o  <= next_addr;
                acc_rdata_o  <= kind_write ? 16'h0000 : fmt_data;
                if (kind_write)
                    last_write_addr <= next_addr;
            end
        end
    end

    // Slot is the word address within the row.
    always @(posedge clk_i)
    begin
        if (take && kind_write)
        begin
            if (!kind_high && !acc_byte_i)
                hold_buf[buf_slot][15:0] <= acc_wdata_i;
            else if (!kind_high && byte_sel)
                hold_buf[buf_slot][15:8] <= acc_wdata_i[7:0];
            else if (!kind_high)
                hold_buf[buf_slot][7:0] <= acc_wdata_i[7:0];
            else if (!acc_byte_i || !byte_sel)
                hold_buf[buf_slot][23:16] <= acc_wdata_i[7:0];
        end
        buf_word_o <= hold_buf[buf_idx_i];
    end

    // The target is aligned to its page, row or word.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            op_start_o <= 1'b0;
            op_kind_o  <= 3'b000;
            op_addr_o  <= 24'h00_0000;
        end
        else
        begin
            op_start_o <= seq_start;
            if (seq_start)
            begin
                op_kind_o <= seq_kind;
                if (seq_kind[0])
                    op_addr_o <= last_write_addr & `PSAU_PAGE_MASK;
                else if (seq_kind[1])
                    op_addr_o <= last_write_addr & `PSAU_ROW_MASK;
                else
                    op_addr_o <= last_write_addr & `PSAU_WORD_MASK;
            end
        end
    end

    // The fetch address keeps the low bit clear.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pc           <= 23'h00_0000;
            fetch_addr_o <= 24'h00_0000;
        end
        else
        begin
            if (pc_load_i)
                pc <= {pc_load_val_i[22:1], 1'b0};
            else if (pc_step_i && !busy)
                pc <= pc + `PSAU_PC_STEP;
            fetch_addr_o <= {1'b0, pc[22:1], 1'b0};
        end
    end

endmodule // psau_top

`default_nettype wire

// File: rtl/psau_defs.vh
`ifndef PSAU_DEFS_VH
`define PSAU_DEFS_VH

`define PSAU_OFS_TABLE_PAGE    8'h00
`define PSAU_OFS_WINDOW_PAGE   8'h04
`define PSAU_OFS_CORE_CONTROL  8'h08
`define PSAU_OFS_FLASH_CONTROL 8'h0C
`define PSAU_OFS_FLASH_KEY     8'h10
`define PSAU_CC_WINDOW_ENABLE  2
`define PSAU_FC_WR             15
`define PSAU_FC_WREN           14
`define PSAU_FC_WRERR          13
`define PSAU_FC_ERASE          6
`define PSAU_TP_CONFIG         7
`define PSAU_RST_PAGE          8'h00
`define PSAU_RST_CTRL          16'h0000
`define PSAU_KEY_FIRST         8'h55
`define PSAU_KEY_SECOND        8'hAA
`define PSAU_OP_PAGE_ERASE     4'h2
`define PSAU_OP_ROW_PROG       4'h1
`define PSAU_OP_WORD_PROG      4'h3
`define PSAU_K_READ_LOW        3'h0
`define PSAU_K_READ_HIGH       3'h1
`define PSAU_K_WRITE_LOW       3'h2
`define PSAU_K_WRITE_HIGH      3'h3
`define PSAU_K_DATA_READ       3'h4

// Two address units per word.
`define PSAU_ROW_WORDS         64
`define PSAU_ROW_MASK          24'hFF_FF80
`define PSAU_PAGE_MASK         24'hFF_FC00
`define PSAU_WORD_MASK         24'hFF_FFFE
`define PSAU_PC_STEP           23'h00_0002
`define PSAU_EXTRA_MOVE        2'h1
`define PSAU_EXTRA_OTHER       2'h2
`define PSAU_EXTRA_NONE        2'h0
`define PSAU_EXTRA_TABLE_WRITE 2'h1

`endif

// File: rtl/psau_read_format.v
`timescale 1ns/1ps
`default_nettype none

module psau_read_format
(
    input  wire        high_i,   // High-word table read
    input  wire        byte_i,   // Byte mode
    input  wire        sel_i,    // Byte select
    input  wire [23:0] pword_i,  // Program word
    output reg  [15:0] data_o    // Formatted data word
);

    always @*
    begin
        if (!high_i && !byte_i)
            data_o = pword_i[15:0];
        else if (!high_i)
            data_o = {8'h00, (sel_i ? pword_i[15:8] : pword_i[7:0])};
        else if (!byte_i)
            data_o = {8'h00, pword_i[23:16]};
        else
            data_o = sel_i ? 16'h0000 : {8'h00, pword_i[23:16]};
    end

endmodule // psau_read_format

`default_nettype wire

// File: rtl/psau_flash_seq.v
`timescale 1ns/1ps
`default_nettype none
`include "psau_defs.vh"

module psau_flash_seq
(
    input  wire       clk_i,      // System clock
    input  wire       rst_i,      // Reset
    input  wire       key_we_i,   // Key write
    input  wire [7:0] key_data_i, // Key value
    input  wire       bus_we_i,   // Any register write
    input  wire       wr_req_i,   // Start request
    input  wire       err_clr_i,  // Error clear
    input  wire       wren_i,     // Write enable bit
    input  wire       erase_i,    // Erase bit
    input  wire [3:0] op_i,       // Operation select
    input  wire       done_i,     // Done
    output wire       busy_o,     // Busy
    output reg        wrerr_o,    // Error flag
    output reg        start_o,    // Launch pulse
    output reg  [2:0] kind_o      // {word, row, page}
);

    localparam ST_IDLE = 2'b01;
    localparam ST_BUSY = 2'b10;
    localparam KEY_NONE  = 3'b001;
    localparam KEY_FIRST = 3'b010;
    localparam KEY_BOTH  = 3'b100;

    reg  [1:0] state;
    reg  [2:0] key_state;
    reg  [1:0] next_state;
    reg  [2:0] next_key_state;
    wire       op_page = erase_i && (op_i == `PSAU_OP_PAGE_ERASE);
    wire       op_row  = !erase_i && (op_i == `PSAU_OP_ROW_PROG);
    wire       op_word = !erase_i && (op_i == `PSAU_OP_WORD_PROG);
    wire       op_ok   = op_page || op_row || op_word;
    wire       launch  = wr_req_i && (state == ST_IDLE) && (key_state == KEY_BOTH) && wren_i && op_ok;
    wire       bad_try = wr_req_i && (state == ST_IDLE) && !launch;

    assign busy_o = (state == ST_BUSY);

    // The keys must land on consecutive register writes; any other write breaks the unlock.
    always @*
    begin
        next_key_state = key_state;
        if (key_we_i)
        begin
            if (key_data_i == `PSAU_KEY_FIRST)
                next_key_state = KEY_FIRST;
            else if (key_data_i == `PSAU_KEY_SECOND && key_state == KEY_FIRST)
                next_key_state = KEY_BOTH;
            else
                next_key_state = KEY_NONE;
        end
        else if (bus_we_i && !wr_req_i)
            next_key_state = KEY_NONE;
        if (wr_req_i)
            next_key_state = KEY_NONE;
    end

    always @*
    begin
        case (state)
            ST_IDLE: next_state = launch ? ST_BUSY : ST_IDLE;
            ST_BUSY: next_state = done_i ? ST_IDLE : ST_BUSY;
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state     <= ST_IDLE;
            key_state <= KEY_NONE;
            wrerr_o   <= 1'b0;
            start_o   <= 1'b0;
            kind_o    <= 3'b000;
        end
        else
        begin
            state     <= next_state;
            key_state <= next_key_state;
            wrerr_o   <= bad_try | (wrerr_o & ~err_clr_i);
            start_o   <= launch;
            if (launch)
                kind_o <= {op_word, op_row, op_page};
        end
    end

endmodule // psau_flash_seq

`default_nettype wire

// File: verif/psau_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module psau_flash_model
#(
    parameter integer DONE_DELAY = 12 // Cycles from launch to completion
)
(
    input  wire logic        clk_i,   // Clock
    input  wire logic        rst_i,   // Reset
    input  wire logic [23:0] addr_i,  // Read address
    output logic      [23:0] data_o,  // Read word
    input  wire logic        start_i, // Launch pulse
    output logic             done_o   // Completion pulse
);
    logic [7:0] cnt;
    // Upper bytes are all ones or zeros, as windowed data should be.
    assign data_o = {{8{|addr_i[2:1]}}, addr_i[16:1] ^ 16'hA5F0};
    always @(posedge clk_i)
    begin
        done_o <= 1'b0;
        if (rst_i)
            cnt <= 8'h00;
        else if (start_i)
            cnt <= DONE_DELAY[7:0];
        else if (cnt != 8'h00)
        begin
            cnt <= cnt - 8'h01;
            done_o <= (cnt == 8'h01);
        end
    end
endmodule // psau_flash_model
`default_nettype wire

// File: verif/psau_props.sv
`timescale 1ns/1ps
`default_nettype none
module psau_props
(
    input wire logic        clk_i,          // Clock
    input wire logic        rst_i,          // Reset
    input wire logic        wb_cyc_i,       // Cycle
    input wire logic        wb_stb_i,       // Strobe
    input wire logic        wb_ack_o,       // Ack
    input wire logic        acc_req_i,      // Request
    input wire logic [2:0]  acc_kind_i,     // Kind
    input wire logic        acc_move_i,     // Move
    input wire logic [15:0] ea_i,           // Address
    input wire logic        rep_active_i,   // Repeat
    input wire logic        rep_first_i,    // First
    input wire logic        rep_last_i,     // Last
    input wire logic        rep_int_exit_i, // Exit
    input wire logic        rep_reentry_i,  // Reentry
    input wire logic        acc_ack_o,      // Answer
    input wire logic [15:0] acc_rdata_o,    // Data
    input wire logic [1:0]  acc_extra_o,    // Extra
    input wire logic        acc_window_o,   // Window
    input wire logic        acc_config_o,   // Config
    input wire logic [23:0] prog_addr_o,    // Address
    input wire logic        stall_o,        // Stall
    input wire logic        op_done_i       // Done
);
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire edge_it = rep_first_i | rep_last_i | rep_int_exit_i | rep_reentry_i;
    a_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered");
    a_acc_answer: assert property (acc_req_i && !stall_o |=> acc_ack_o)
        else $error("access not answered");
    a_stall_drop: assert property (acc_req_i && stall_o |=> !acc_ack_o)
        else $error("access answered while stalled");
    a_table_addr: assert property (acc_ack_o && $past(acc_kind_i) != 3'h4 |->
        prog_addr_o[15:0] == $past(ea_i) && acc_config_o == prog_addr_o[23])
        else $error("table address wrong");
    a_no_window: assert property (acc_ack_o && $past(acc_kind_i) != 3'h4 |-> !acc_window_o)
        else $error("table access windowed");
    a_window_addr: assert property (acc_ack_o && acc_window_o |-> $past(ea_i[15]) &&
        !prog_addr_o[23] && prog_addr_o[14:0] == $past(ea_i[14:0]))
        else $error("window address wrong");
    a_phantom_zero: assert property (acc_ack_o && $past(acc_kind_i) == 3'h1 |-> acc_rdata_o[15:8] == 8'h00)
        else $error("phantom byte not zero");
    a_move_extra: assert property (acc_ack_o && acc_window_o && !$past(rep_active_i) |->
        acc_extra_o == ($past(acc_move_i) ? 2'h1 : 2'h2))
        else $error("penalty outside repeat wrong");
    a_rep_extra: assert property (acc_ack_o && acc_window_o && $past(rep_active_i) |->
        acc_extra_o == ($past(edge_it) ? 2'h2 : 2'h0))
        else $error("penalty inside repeat wrong");
    a_stall_hold: assert property (stall_o && !op_done_i |=> stall_o)
        else $error("stall ended early");
    a_done_clear: assert property (stall_o && op_done_i |=> !stall_o)
        else $error("stall kept after completion");
endmodule // psau_props
bind psau_top psau_props i_props (.*);
`default_nettype wire

// File: verif/test_program_space_access_unit.sv
`timescale 1ns/1ps
`default_nettype none
module test_program_space_access_unit;
    typedef struct packed {logic [2:0] k; logic b; logic m; logic [15:0] ea; logic [4:0] rp; logic [1:0] ex;} psau_row_t;
    localparam logic [7:0] TP = 8'h12;
    localparam logic [7:0] WP = 8'h34;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_stb_i = 1'b0, wb_cyc_i = 1'b0;
    logic acc_req_i = 1'b0, acc_byte_i = 1'b0, acc_move_i = 1'b0, pc_load_i = 1'b0, pc_step_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000, rd;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [2:0]  acc_kind_i = 3'h0;
    logic [15:0] ea_i = 16'h0000, acc_wdata_i = 16'h0000;
    logic [4:0]  rp = 5'h00;
    logic [22:0] pc_load_val_i = 23'h00_0000;
    logic [5:0]  buf_idx_i = 6'h21;
    logic [23:0] ad;
    wire rep_active_i = rp[4], rep_first_i = rp[3], rep_last_i = rp[2], rep_int_exit_i = rp[1], rep_reentry_i = rp[0];
    wire wb_ack_o, acc_ack_o, acc_window_o, acc_config_o, stall_o, op_start_o, op_done_i;
    wire [31:0] wb_dat_o;
    wire [15:0] acc_rdata_o;
    wire [1:0]  acc_extra_o;
    wire [2:0]  op_kind_o;
    wire [23:0] prog_addr_o, fetch_addr_o, flash_rd_addr_o, flash_rd_data_i, op_addr_o, buf_word_o;
    integer i, num_errors = 0, tests_run = 0;
    psau_row_t r;
    psau_row_t rows [14] = '{
        '{3'h0, 1'b0, 1'b0, 16'h4000, 5'h00, 2'h0}, '{3'h0, 1'b1, 1'b0, 16'h4001, 5'h00, 2'h0},
        '{3'h0, 1'b1, 1'b0, 16'h4000, 5'h00, 2'h0}, '{3'h1, 1'b0, 1'b0, 16'h8002, 5'h00, 2'h0},
        '{3'h1, 1'b1, 1'b0, 16'h8004, 5'h00, 2'h0}, '{3'h1, 1'b1, 1'b0, 16'h8005, 5'h00, 2'h0},
        '{3'h4, 1'b0, 1'b1, 16'h9006, 5'h00, 2'h1}, '{3'h4, 1'b0, 1'b0, 16'h9008, 5'h00, 2'h2},
        '{3'h4, 1'b0, 1'b0, 16'h1008, 5'h00, 2'h0}, '{3'h4, 1'b0, 1'b1, 16'h900A, 5'h10, 2'h0},
        '{3'h4, 1'b0, 1'b0, 16'h900C, 5'h18, 2'h2}, '{3'h4, 1'b0, 1'b0, 16'h900E, 5'h14, 2'h2},
        '{3'h4, 1'b0, 1'b0, 16'h9010, 5'h12, 2'h2}, '{3'h4, 1'b0, 1'b0, 16'h9012, 5'h11, 2'h2}};

    psau_top i_dut (.*);
    psau_flash_model i_flash (.clk_i(clk_i), .rst_i(rst_i), .addr_i(flash_rd_addr_o), .data_o(flash_rd_data_i),
        .start_i(op_start_o), .done_o(op_done_i));

    initial
    begin
        forever #20 clk_i = ~clk_i;
    end

    function automatic logic [23:0] pat(input logic [23:0] a);
        pat = {{8{|a[2:1]}}, a[16:1] ^ 16'hA5F0};
    endfunction

    function automatic logic [15:0] fmt(input logic [2:0] k, input logic b, input logic s, input logic [23:0] p);
        if (k == 3'h1)
            fmt = (b && s) ? 16'h0000 : {8'h00, p[23:16]};
        else if (b)
            fmt = s ? {8'h00, p[15:8]} : {8'h00, p[7:0]};
        else
            fmt = p[15:0];
    endfunction

    task stop_test;
        begin
            $display("checks %0d mismatches %0d", tests_run, num_errors);
            if (num_errors == 0 && tests_run > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    task chk(input string nm, input logic [31:0] ex, got);
        begin
            tests_run++;
            if (got !== ex)
            begin
                num_errors++;
                $display("BAD %s expected %h seen %h", nm, ex, got);
            end
        end
    endtask

    task hang(input integer n, input integer lim);
        begin
            if (n >= lim)
            begin
                chk("wait", 32'h0000_0001, 32'h0000_0000);
                stop_test;
            end
        end
    endtask

    task wb(input logic [7:0] a, input logic [31:0] d, input logic w);
        integer n;
        begin
            wb_adr_i <= a;
            wb_dat_i <= d;
            wb_we_i <= w;
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            for (n = 0; n < 9 && wb_ack_o !== 1'b1; n = n + 1)
                @(posedge clk_i);
            hang(n, 9);
            rd = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            @(posedge clk_i);
        end
    endtask

    task acc(input logic [2:0] k, input logic b, m, input logic [15:0] a, d, input logic [4:0] x, input logic ek);
        begin
            acc_kind_i <= k;
            acc_byte_i <= b;
            acc_move_i <= m;
            ea_i <= a;
            acc_wdata_i <= d;
            rp <= x;
            acc_req_i <= 1'b1;
            @(posedge clk_i);
            acc_req_i <= 1'b0;
            @(posedge clk_i);
            chk("ack", ek, acc_ack_o);
        end
    endtask

    task launch(input logic [15:0] c, input logic [2:0] k, input logic [23:0] a);
        integer n;
        begin
            wb(8'h0C, {16'h0000, c}, 1'b1);
            wb(8'h10, 32'h0000_0055, 1'b1);
            wb(8'h10, 32'h0000_00AA, 1'b1);
            wb(8'h0C, {16'h0000, c | 16'h8000}, 1'b1);
            for (n = 0; n < 9 && op_start_o !== 1'b1; n = n + 1)
                @(posedge clk_i);
            hang(n, 9);
            chk("kind", k, op_kind_o);
            chk("target", a, op_addr_o);
            acc(3'h0, 1'b0, 1'b0, 16'h0000, 16'h0000, 5'h00, 1'b0);
            for (n = 0; n < 60 && stall_o !== 1'b0; n = n + 1)
                @(posedge clk_i);
            hang(n, 60);
            wb(8'h0C, 32'h0000_0000, 1'b0);
            chk("control", {16'h0000, c}, rd);
        end
    endtask

    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(8'h0C, 32'h0000_0000, 1'b0);
        chk("control reset", 32'h0000_0000, rd);
        wb(8'h00, {24'h00_0000, TP}, 1'b1);
        wb(8'h04, {24'h00_0000, WP}, 1'b1);
        wb(8'h08, 32'h0000_0004, 1'b1);
        for (i = 0; i < 14; i = i + 1)
        begin
            r = rows[i];
            acc(r.k, r.b, r.m, r.ea, 16'h0000, r.rp, 1'b1);
            ad = (r.k != 3'h4) ? {TP, r.ea} : (r.ea[15] ? {1'b0, WP, r.ea[14:0]} : {8'h00, r.ea});
            chk("address", ad, prog_addr_o);
            chk("data", fmt(r.k, r.b, r.ea[0], pat(ad)), acc_rdata_o);
            chk("window", r.k == 3'h4 && r.ea[15], acc_window_o);
            chk("extra", r.ex, acc_extra_o);
        end
        $display("access table done");
        pc_load_val_i <= 23'h00_0100;
        pc_load_i <= 1'b1;
        @(posedge clk_i);
        pc_load_i <= 1'b0;
        pc_step_i <= 1'b1;
        @(posedge clk_i);
        pc_step_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("fetch", 24'h00_0102, fetch_addr_o);
        wb(8'h08, 32'h0000_0000, 1'b1);
        acc(3'h4, 1'b0, 1'b0, 16'h9006, 16'h0000, 5'h00, 1'b1);
        chk("window off", 1'b0, acc_window_o);
        wb(8'h00, 32'h0000_0092, 1'b1);
        acc(3'h0, 1'b0, 1'b0, 16'h0010, 16'h0000, 5'h00, 1'b1);
        chk("config", 1'b1, acc_config_o);
        wb(8'h00, {24'h00_0000, TP}, 1'b1);
        for (i = 0; i < 128; i = i + 1)
        begin
            acc(3'h2 + i[0], 1'b0, 1'b0, 16'h0100 + i[6:1] * 2, {10'h000, i[6:1]}, 5'h00, 1'b1);
            chk("write extra", 2'h1, acc_extra_o);
        end
        repeat (2) @(posedge clk_i);
        chk("buffer", 24'h21_0021, buf_word_o);
        launch(16'h4042, 3'h1, 24'h12_0000);
        launch(16'h4001, 3'h2, 24'h12_0100);
        launch(16'h4003, 3'h4, 24'h12_017E);
        wb(8'h0C, 32'h0000_C042, 1'b1);
        repeat (3) @(posedge clk_i);
        chk("no launch", 1'b0, stall_o);
        wb(8'h0C, 32'h0000_0000, 1'b0);
        chk("error flag", 32'h0000_6042, rd);
        wb(8'h20, 32'h0000_0000, 1'b0);
        chk("unmapped", 32'h0000_0000, rd);
        wb(8'h10, 32'h0000_0000, 1'b0);
        chk("key read", 32'h0000_0000, rd);
        $display("special cases done");
        stop_test;
    end
endmodule // test_program_space_access_unit
`default_nettype wire
